// ===== logic/pcrb_map.vh
// Purpose: register offsets, field positions and reset values of the port register bank
// Assumes: byte offsets within the port configuration space
// Notes: definitions only
`ifndef PCRB_MAP_VH
`define PCRB_MAP_VH
`define PCRB_OFF_MSI_ADDR_LO 12'h084
`define PCRB_OFF_IRQ_MSG_PAYLOAD 12'h088
`define PCRB_OFF_IRQ_MSG_PAYLOAD_WIDE 12'h08c
`define PCRB_OFF_RETRY_TIMER 12'h090
`define PCRB_OFF_IO_CTRL 12'h094
`define PCRB_OFF_SSID_CAP 12'h0b0
`define PCRB_OFF_SUBSYSTEM_IDENTITY 12'h0b4
`define PCRB_OFF_MAP_CAP 12'h0b8
`define PCRB_OFF_INDEX 12'h0e0
`define PCRB_OFF_DATA 12'h0e4
`define PCRB_OFF_AER_HDR 12'h140
`define PCRB_OFF_UNC_STATUS 12'h144
`define PCRB_OFF_UNC_MASK 12'h148
`define PCRB_OFF_UNC_SEV 12'h14c
`define PCRB_OFF_COR_STATUS 12'h150
`define PCRB_OFF_COR_MASK 12'h154
`define PCRB_OFF_AER_CTRL 12'h158
`define PCRB_SSID_CAP_VALUE 32'h0000_b80d
`define PCRB_MAP_CAP_VALUE 32'ha803_0008
`define PCRB_AER_HDR_VALUE 32'h0001_0001
`define PCRB_UNC_SRC_MASK 32'h001f_f030
`define PCRB_UNC_SEV_RESET 32'h0006_2030
`define PCRB_COR_SRC_MASK 32'h0000_31c1
`define PCRB_COR_MASK_RESET 32'h0000_2000
`define PCRB_IO_CTRL_MASK 32'h0000_3f87
`define PCRB_ADDR_LO_MASK 32'hffff_fffc
`define PCRB_DATA_MASK 32'h0000_ffff
`define PCRB_RETRY_DELAY_LSB 0
`define PCRB_RETRY_LIMIT_LSB 24
`define PCRB_INDEX_MASK 32'h0000_00ff
`define PCRB_PTR_W 5
`define PCRB_UNC_FIRST_BIT 4
`define PCRB_UNC_LAST_BIT 20
`define PCRB_ZERO32 32'h0000_0000
`endif

// ===== logic/pcrb_indirect_mem.v
// Purpose: storage for the port's indirect registers behind the index/data window
// Assumes: one access per cycle, same clock as the bank
// Notes: read data comes out of a register
`timescale 1ns/1ps
`default_nettype none
module pcrb_indirect_mem #(
  parameter AW = 8,
  parameter DW = 32
) (
  input wire ref_clk,
  input wire [AW-1:0] addr,
  input wire wr_en,
  input wire [DW-1:0] wr_data,
  output reg [DW-1:0] rd_data_q
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  always @(posedge ref_clk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
    rd_data_q <= mem[addr];
  end
endmodule
`default_nettype wire

// ===== logic/pcrb_first_err.v
// Purpose: lowest-position finder for uncorrectable error events
// Assumes: events arrive as a bit vector
// Notes: combinational, lowest set bit wins
`timescale 1ns/1ps
`default_nettype none
module pcrb_first_err #(
  parameter W = 32,
  parameter PW = 5
) (
  input wire [W-1:0] vec,
  output reg any,
  output reg [PW-1:0] pos
);
  integer i;
  always @* begin
    any = 1'b0;
    pos = {PW{1'b0}};
    for (i = W - 1; i >= 0; i = i - 1) begin
      if (vec[i]) begin
        any = 1'b1;
        pos = i[PW-1:0];
      end
    end
  end
endmodule
`default_nettype wire

// ===== logic/pcrb_port_regs.v
// What this block does
// - Subsystem capability header reads id 0xd, next pointer 0xb8, read-only.
// - Mapping capability reads id 0x8, enable and fixed set, type 0x15, read-only.
// - Mapping capability next pointer reads zero, ending the list.
// - Software writes an 8-bit index; it selects the indirect register reached.
// - Data window reads and writes the indirect register the index selects.
// - Retry timer holds 24-bit delay and 8-bit limit, both reset zero.
// - I/O control bits 0..2 give inbound ordering and snoop overrides.
// - I/O control bits 8..13 give outbound ordering and snoop controls.
// - I/O control bit 7 blocks master bit set; all bits reset zero.
// - Extended error header reads id 0x1 and version 0x1.
// - Extended error header next pointer reads zero.
// - Uncorrectable status records each listed source at its own bit.
// - Uncorrectable mask per source suppresses messages; resets zero.
// - Severity selects fatal per source; reset one for five listed sources.
// - Correctable status records receiver, packet, replay and advisory sources.
// - Correctable mask suppresses messages; only advisory bit resets to one.
// - Interrupt capability reports no 64-bit address; high word reads zero.
// - Read-only 5-bit pointer holds first recorded uncorrectable error position.
// Purpose: per-port configuration register bank of a root port
// Assumes: config access strobes are single-cycle, on ref_clk
// Notes: read data is registered, valid one cycle after the read strobe, two cycles for the data window
`timescale 1ns/1ps
`default_nettype none
`include "pcrb_map.vh"
module pcrb_port_regs #(
  parameter IDX_W = 8
) (
  input wire ref_clk,
  input wire reset_n,
  input wire cfg_rd,
  input wire cfg_wr,
  input wire [11:0] cfg_addr,
  input wire [31:0] cfg_wdata,
  output reg [31:0] cfg_rdata_q,
  output reg cfg_rvalid_q,
  input wire [31:0] unc_err_event,
  input wire [31:0] cor_err_event,
  output reg err_msg_cor_q,
  output reg err_msg_nonfatal_q,
  output reg err_msg_fatal_q,
  output wire [31:0] irq_msg_address_low,
  output wire [15:0] irq_msg_payload,
  output wire wide_address_capable,
  output wire [23:0] retry_delay_count,
  output wire [7:0] retry_limit_count,
  output wire inbound_force_relaxed,
  output wire inbound_force_coherent,
  output wire inbound_attr_override_on,
  output wire master_bit_set_block,
  output wire outbound_strict_ordering,
  output wire outbound_block_noncoherent,
  output wire outbound_block_coherent,
  output wire outbound_force_relaxed,
  output wire outbound_permit_relaxed,
  output wire outbound_permit_noncoherent,
  output wire [31:0] subsystem_identity
);
  reg [31:0] addr_lo_q;
  reg [31:0] msg_data_q;
  reg [31:0] retry_q;
  reg [31:0] io_ctrl_q;
  reg [31:0] ssid_q;
  reg [31:0] index_q;
  reg [31:0] unc_status_q;
  reg [31:0] unc_mask_q;
  reg [31:0] unc_sev_q;
  reg [31:0] cor_status_q;
  reg [31:0] cor_mask_q;
  reg [`PCRB_PTR_W-1:0] first_ptr_q;
  reg first_valid_q;
  reg data_rd_q;
  reg [31:0] rdata_d;
  wire [31:0] ind_rdata;
  wire unc_any;
  wire [`PCRB_PTR_W-1:0] unc_pos;
  wire [31:0] unc_ev = unc_err_event & `PCRB_UNC_SRC_MASK;
  wire [31:0] cor_ev = cor_err_event & `PCRB_COR_SRC_MASK;
  wire [31:0] unc_new = unc_ev & ~unc_status_q;
  wire [31:0] unc_rep = unc_ev & ~unc_mask_q;
  wire [31:0] cor_rep = cor_ev & ~cor_mask_q;
  wire wr_hit_unc = cfg_wr && (cfg_addr == `PCRB_OFF_UNC_STATUS);
  wire wr_hit_cor = cfg_wr && (cfg_addr == `PCRB_OFF_COR_STATUS);
  wire data_hit = (cfg_addr == `PCRB_OFF_DATA);

  pcrb_indirect_mem #(
    .AW(IDX_W),
    .DW(32)
  ) u_mem (
    .ref_clk(ref_clk),
    .addr(index_q[IDX_W-1:0]),
    .wr_en(cfg_wr && data_hit),
    .wr_data(cfg_wdata),
    .rd_data_q(ind_rdata)
  );

  pcrb_first_err #(
    .W(32),
    .PW(`PCRB_PTR_W)
  ) u_first (
    .vec(unc_new),
    .any(unc_any),
    .pos(unc_pos)
  );

  // Register writes
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_lo_q <= `PCRB_ZERO32;
      msg_data_q <= `PCRB_ZERO32;
      retry_q <= `PCRB_ZERO32;
      io_ctrl_q <= `PCRB_ZERO32;
      ssid_q <= `PCRB_ZERO32;
      index_q <= `PCRB_ZERO32;
      unc_mask_q <= `PCRB_ZERO32;
      unc_sev_q <= `PCRB_UNC_SEV_RESET;
      cor_mask_q <= `PCRB_COR_MASK_RESET;
    end else if (cfg_wr) begin
      case (cfg_addr)
        `PCRB_OFF_MSI_ADDR_LO: addr_lo_q <= cfg_wdata & `PCRB_ADDR_LO_MASK;
        `PCRB_OFF_IRQ_MSG_PAYLOAD: msg_data_q <= cfg_wdata & `PCRB_DATA_MASK;
        `PCRB_OFF_RETRY_TIMER: retry_q <= cfg_wdata;
        `PCRB_OFF_IO_CTRL: io_ctrl_q <= cfg_wdata & `PCRB_IO_CTRL_MASK;
        `PCRB_OFF_SUBSYSTEM_IDENTITY: ssid_q <= cfg_wdata;
        `PCRB_OFF_INDEX: index_q <= cfg_wdata & `PCRB_INDEX_MASK;
        `PCRB_OFF_UNC_MASK: unc_mask_q <= cfg_wdata & `PCRB_UNC_SRC_MASK;
        `PCRB_OFF_UNC_SEV: unc_sev_q <= cfg_wdata & `PCRB_UNC_SRC_MASK;
        `PCRB_OFF_COR_MASK: cor_mask_q <= cfg_wdata & `PCRB_COR_SRC_MASK;
        default: addr_lo_q <= addr_lo_q;
      endcase
    end
  end

  // Sticky status: set wins over write-one clear, mask does not gate recording
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      unc_status_q <= `PCRB_ZERO32;
      cor_status_q <= `PCRB_ZERO32;
    end else begin
      unc_status_q <= (unc_status_q & ~(wr_hit_unc ? cfg_wdata : `PCRB_ZERO32)) | unc_ev;
      cor_status_q <= (cor_status_q & ~(wr_hit_cor ? cfg_wdata : `PCRB_ZERO32)) | cor_ev;
    end
  end

  // First error pointer: captured when no pointer is held, i.e. after the status bit it named was cleared
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      first_ptr_q <= {`PCRB_PTR_W{1'b0}};
      first_valid_q <= 1'b0;
    end else begin
      if (unc_any && !first_valid_q) begin
        first_ptr_q <= unc_pos;
        first_valid_q <= 1'b1;
      end else if (wr_hit_unc && cfg_wdata[first_ptr_q] && !unc_ev[first_ptr_q]) begin
        first_valid_q <= 1'b0;
      end
    end
  end

  // Error messages, one-cycle pulses
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      err_msg_cor_q <= 1'b0;
      err_msg_nonfatal_q <= 1'b0;
      err_msg_fatal_q <= 1'b0;
    end else begin
      err_msg_cor_q <= |cor_rep;
      err_msg_fatal_q <= |(unc_rep & unc_sev_q);
      err_msg_nonfatal_q <= |(unc_rep & ~unc_sev_q);
    end
  end

  // Read mux
  always @* begin
    case (cfg_addr)
      `PCRB_OFF_MSI_ADDR_LO: rdata_d = addr_lo_q;
      `PCRB_OFF_IRQ_MSG_PAYLOAD: rdata_d = msg_data_q;
      `PCRB_OFF_IRQ_MSG_PAYLOAD_WIDE: rdata_d = `PCRB_ZERO32;
      `PCRB_OFF_RETRY_TIMER: rdata_d = retry_q;
      `PCRB_OFF_IO_CTRL: rdata_d = io_ctrl_q;
      `PCRB_OFF_SSID_CAP: rdata_d = `PCRB_SSID_CAP_VALUE;
      `PCRB_OFF_SUBSYSTEM_IDENTITY: rdata_d = ssid_q;
      `PCRB_OFF_MAP_CAP: rdata_d = `PCRB_MAP_CAP_VALUE;
      `PCRB_OFF_INDEX: rdata_d = index_q;
      `PCRB_OFF_AER_HDR: rdata_d = `PCRB_AER_HDR_VALUE;
      `PCRB_OFF_UNC_STATUS: rdata_d = unc_status_q;
      `PCRB_OFF_UNC_MASK: rdata_d = unc_mask_q;
      `PCRB_OFF_UNC_SEV: rdata_d = unc_sev_q;
      `PCRB_OFF_COR_STATUS: rdata_d = cor_status_q;
      `PCRB_OFF_COR_MASK: rdata_d = cor_mask_q;
      `PCRB_OFF_AER_CTRL: rdata_d = {{(32-`PCRB_PTR_W){1'b0}}, first_ptr_q};
      default: rdata_d = `PCRB_ZERO32;
    endcase
  end

  // Read answer: one cycle, data window two cycles (memory is registered)
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_rdata_q <= `PCRB_ZERO32;
      cfg_rvalid_q <= 1'b0;
      data_rd_q <= 1'b0;
    end else begin
      data_rd_q <= cfg_rd && data_hit;
      cfg_rvalid_q <= (cfg_rd && !data_hit) || data_rd_q;
      if (data_rd_q) begin
        cfg_rdata_q <= ind_rdata;
      end else if (cfg_rd && !data_hit) begin
        cfg_rdata_q <= rdata_d;
      end
    end
  end

  assign irq_msg_address_low = addr_lo_q;
  assign irq_msg_payload = msg_data_q[15:0];
  assign wide_address_capable = 1'b0;
  assign retry_delay_count = retry_q[`PCRB_RETRY_LIMIT_LSB-1:`PCRB_RETRY_DELAY_LSB];
  assign retry_limit_count = retry_q[31:`PCRB_RETRY_LIMIT_LSB];
  assign inbound_force_relaxed = io_ctrl_q[0];
  assign inbound_force_coherent = io_ctrl_q[1];
  assign inbound_attr_override_on = io_ctrl_q[2];
  assign master_bit_set_block = io_ctrl_q[7];
  assign outbound_strict_ordering = io_ctrl_q[8];
  assign outbound_block_noncoherent = io_ctrl_q[9];
  assign outbound_block_coherent = io_ctrl_q[10];
  assign outbound_force_relaxed = io_ctrl_q[11];
  assign outbound_permit_relaxed = io_ctrl_q[12];
  assign outbound_permit_noncoherent = io_ctrl_q[13];
  assign subsystem_identity = ssid_q;
endmodule
`default_nettype wire

// ===== sim/pcrb_port_regs_monitor.sv
// Purpose: port-level checks of the register bank
// Assumes: one clock, async active-low reset
// Notes: bound to pcrb_port_regs
`timescale 1ns/1ps
`default_nettype none
module pcrb_port_regs_monitor (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [31:0] cfg_rdata_q,
  input wire logic cfg_rvalid_q,
  input wire logic [31:0] unc_err_event,
  input wire logic [31:0] cor_err_event,
  input wire logic err_msg_cor_q,
  input wire logic err_msg_fatal_q,
  input wire logic [31:0] irq_msg_address_low,
  input wire logic wide_address_capable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_subsys_hdr_value: assert property (cfg_rd && cfg_addr == 12'h0b0 |=>
    cfg_rdata_q == 32'h0000_b80d) else $error("subsystem header");
  a_map_cap_value: assert property (cfg_rd && cfg_addr == 12'h0b8 |=>
    cfg_rdata_q == 32'ha803_0008) else $error("mapping header");
  a_ext_hdr_value: assert property (cfg_rd && cfg_addr == 12'h140 |=>
    cfg_rdata_q == 32'h0001_0001) else $error("extended header");
  a_window_read_delay: assert property (cfg_rd && cfg_addr == 12'h0e4 |=>
    !cfg_rvalid_q ##1 cfg_rvalid_q) else $error("window read timing");
  a_fatal_has_cause: assert property (err_msg_fatal_q |->
    |($past(unc_err_event) & 32'h001f_f030)) else $error("fatal without event");
  a_cor_has_cause: assert property (err_msg_cor_q |->
    |($past(cor_err_event) & 32'h0000_31c1)) else $error("correctable without event");
  a_no_wide_address: assert property (wide_address_capable == 1'b0)
    else $error("wide address reported");
  a_address_dword_aligned: assert property (irq_msg_address_low[1:0] == 2'b00)
    else $error("address not aligned");
  cover property (cfg_rd && cfg_addr == 12'h0e4);
  cover property (err_msg_fatal_q);
  cover property (err_msg_cor_q);
endmodule
bind pcrb_port_regs pcrb_port_regs_monitor u_mon (.ref_clk(ref_clk), .reset_n(reset_n),
  .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_rdata_q(cfg_rdata_q), .cfg_rvalid_q(cfg_rvalid_q),
  .unc_err_event(unc_err_event), .cor_err_event(cor_err_event), .err_msg_cor_q(err_msg_cor_q),
  .err_msg_fatal_q(err_msg_fatal_q), .irq_msg_address_low(irq_msg_address_low),
  .wide_address_capable(wide_address_capable));
`default_nettype wire

// ===== sim/pcrb_port_regs_tb_top.sv
// Purpose: self-checking bench of the register bank
// Assumes: 250 MHz clock, async active-low reset
// Notes: window reads answer one cycle later than others
`timescale 1ns/1ps
`default_nettype none
module pcrb_port_regs_tb_top;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [11:0] a = 12'h000;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] ue = 32'h0000_0000;
  logic [31:0] ce = 32'h0000_0000;
  wire [31:0] rdata, alo, ssid;
  wire [23:0] dly;
  wire [7:0] lim;
  wire [9:0] io;
  wire [15:0] pl;
  wire rv, mc, mn, mf, wac;
  int error_cnt = 0;
  int check_count = 0;
  logic [11:0] ra [16] = '{12'h084, 12'h088, 12'h08c, 12'h090, 12'h094, 12'h0b0, 12'h0b8,
    12'h140, 12'h0b4, 12'h0f0, 12'h144, 12'h148, 12'h14c, 12'h150, 12'h154, 12'h158};
  logic [31:0] rz [16] = '{0, 0, 0, 0, 0, 32'h0000_b80d, 32'ha803_0008, 32'h0001_0001, 0, 0,
    0, 0, 32'h0006_2030, 0, 32'h0000_2000, 0};
  logic [31:0] rw [10] = '{32'hffff_fffc, 32'h0000_ffff, 0, 32'hffff_ffff, 32'h0000_3f87,
    32'h0000_b80d, 32'ha803_0008, 32'h0001_0001, 32'hffff_ffff, 0};
  always #2 ref_clk = ~ref_clk;
  pcrb_port_regs dut (.ref_clk(ref_clk), .reset_n(reset_n), .cfg_rd(rd), .cfg_wr(wr),
    .cfg_addr(a), .cfg_wdata(wd), .cfg_rdata_q(rdata), .cfg_rvalid_q(rv), .unc_err_event(ue),
    .cor_err_event(ce), .err_msg_cor_q(mc), .err_msg_nonfatal_q(mn), .err_msg_fatal_q(mf),
    .irq_msg_address_low(alo), .irq_msg_payload(pl), .wide_address_capable(wac),
    .retry_delay_count(dly), .retry_limit_count(lim), .inbound_force_relaxed(io[0]),
    .inbound_force_coherent(io[1]), .inbound_attr_override_on(io[2]),
    .master_bit_set_block(io[3]), .outbound_strict_ordering(io[4]),
    .outbound_block_noncoherent(io[5]), .outbound_block_coherent(io[6]),
    .outbound_force_relaxed(io[7]), .outbound_permit_relaxed(io[8]),
    .outbound_permit_noncoherent(io[9]), .subsystem_identity(ssid));
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cw(input logic [11:0] ad, input logic [31:0] d);
    @(posedge ref_clk);
    wr <= 1'b1;
    a <= ad;
    wd <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rc(input logic [11:0] ad, input logic [31:0] exp);
    int n;
    @(posedge ref_clk);
    rd <= 1'b1;
    a <= ad;
    @(posedge ref_clk);
    rd <= 1'b0;
    n = 0;
    #1;
    while (rv !== 1'b1 && n < 4) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (rv !== 1'b1) begin
      error_cnt++;
      $display("Error %0t: no read answer", $time);
      summarize();
    end else begin
      chk(rdata, exp);
    end
  endtask
  // Event pulse, then collect {fatal, nonfatal, correctable} over three cycles
  task automatic ev(input logic [31:0] u, input logic [31:0] c, input logic [2:0] exp);
    logic [2:0] seen;
    seen = 3'b000;
    @(posedge ref_clk);
    ue <= u;
    ce <= c;
    @(posedge ref_clk);
    ue <= 32'h0000_0000;
    ce <= 32'h0000_0000;
    repeat (3) begin
      #1;
      seen = seen | {mf, mn, mc};
      @(posedge ref_clk);
    end
    chk({29'h0, seen}, {29'h0, exp});
  endtask
  // Reset values of every register except index and data window, and of the control outputs
  task automatic scn_reset_values;
    for (int i = 0; i < 16; i++) rc(ra[i], rz[i]);
    chk({22'h0, io}, 32'h0000_0000);
    chk({31'h0, wac}, 32'h0000_0000);
  endtask
  // All-ones writes: writable bits stick, read-only words keep their values
  task automatic scn_write_ones;
    for (int i = 0; i < 10; i++) cw(ra[i], 32'hffff_ffff);
    for (int i = 0; i < 10; i++) rc(ra[i], rw[i]);
    chk(alo, 32'hffff_fffc);
    chk({16'h0, pl}, 32'h0000_ffff);
    chk({lim, dly}, 32'hffff_ffff);
    chk({22'h0, io}, 32'h0000_03ff);
    chk(ssid, 32'hffff_ffff);
    chk({31'h0, wac}, 32'h0000_0000);
  endtask
  // Index and data window reach separate indirect words
  task automatic scn_window;
    cw(12'h0e0, 32'h1234_5605);
    cw(12'h0e4, 32'h1111_2222);
    cw(12'h0e0, 32'h0000_00ff);
    cw(12'h0e4, 32'h3333_4444);
    cw(12'h0e0, 32'h0000_0005);
    rc(12'h0e4, 32'h1111_2222);
    rc(12'h0e0, 32'h0000_0005);
    cw(12'h0e0, 32'h0000_00ff);
    rc(12'h0e4, 32'h3333_4444);
  endtask
  // Error recording, clearing, masking, severity and first-error pointer
  task automatic scn_errors;
    ev(32'h0000_0010, 32'h0000_0000, 3'b100);
    ev(32'h0000_1000, 32'h0000_0000, 3'b010);
    rc(12'h144, 32'h0000_1010);
    rc(12'h158, 32'h0000_0004);
    cw(12'h144, 32'h0000_0010);
    rc(12'h144, 32'h0000_1000);
    cw(12'h148, 32'h0010_0000);
    ev(32'h0010_0000, 32'h0000_0000, 3'b000);
    rc(12'h144, 32'h0010_1000);
    rc(12'h158, 32'h0000_0014);
    cw(12'h14c, 32'h0000_1000);
    ev(32'h0000_1000, 32'h0000_0000, 3'b100);
    ev(32'h0000_0000, 32'h0000_2000, 3'b000);
    ev(32'h0000_0000, 32'h0000_0041, 3'b001);
    rc(12'h150, 32'h0000_2041);
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    scn_reset_values();
    scn_write_ones();
    scn_window();
    scn_errors();
    summarize();
  end
endmodule
`default_nettype wire
